// [hdl/acc_pinmux.sv]
// Priority selection for the two shared comparator input pins
`timescale 1ns/1ps
module acc_pinmux (
  // Inverting-input pin requests
  input wire logic neg_conv_ref_req,
  input wire logic neg_cmp_req,
  input wire logic neg_conv_ch_req,
  // Non-inverting-input pin requests
  input wire logic pos_cmp_req,
  input wire logic pos_conv_ch_req,
  // Grants, one-hot: converter ref (inverting pin only), comparator, converter channel, port
  output logic [3:0] neg_grant,
  output logic [2:0] pos_grant
);
  assign neg_grant = neg_conv_ref_req ? 4'h8 : // R12
                     neg_cmp_req ? 4'h4 :
                     neg_conv_ch_req ? 4'h2 : 4'h1;
  assign pos_grant = pos_cmp_req ? 3'h4 : // R13
                     pos_conv_ch_req ? 3'h2 : 3'h1;
endmodule

// [hdl/acc_pkg.sv]
// Constants for the analog comparator control block
// Summary of operation
// R1: The comparator output is the result of comparing the inverting input against the non-inverting input.
// R2: With the internal reference enabled, the inverting input is taken from the reference generator.
// R3: The 4-bit ratio field selects a reference of supply times n/15, all ones (full supply) by default.
// R4: The current result is readable as a read-only bit at position 2 of the comparator control register.
// R5: With the routing field at binary 10 the result is driven onto the comparator output pin.
// R6: A comparator interrupt request needs the mask bit 7 of the interrupt mask register and global enable; a Sleep wake-up raises it without either.
// R7: The interrupt flag is set on every rising and every falling change of the comparator output.
// R8: The interrupt flag at status bit 7 stays set until software writes it clear.
// R9: An enabled comparator keeps working with its change detection and interrupt logic during Sleep.
// R10: A change detected during Sleep raises the interrupt and ends Sleep.
// R11: Software should turn the comparator off before Sleep when wake-up is not needed.
// R12: The inverting-input pin serves converter reference, then comparator, then converter channel, then port.
// R13: The non-inverting-input pin serves comparator, then converter channel, then port.
// R14: The comparator wake enable bit gates whether a change may end Sleep.
// R15: The result is synchronised to the clock before edge detection so one change sets one event.
package acc_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] ACC_OFS_CMP_CTRL = 8'h09;
  localparam logic [7:0] ACC_OFS_WAKE_CTRL = 8'h0D;
  localparam logic [7:0] ACC_OFS_IRQ_STATUS = 8'h0F;
  // Mask shares offset 0F on another page; the page bit selects it
  localparam logic [7:0] ACC_OFS_IRQ_MASK = 8'h0F;
  localparam logic [7:0] ACC_PAGE_BIT = 8'h80;

  // ==========================================================================
  // Field positions
  localparam int ACC_BIT_REF_SEL_N = 7;
  localparam int ACC_BIT_RATIO_HI = 6;
  localparam int ACC_BIT_RATIO_LO = 3;
  localparam int ACC_BIT_RESULT = 2;
  localparam int ACC_BIT_ROUTE_HI = 1;
  localparam int ACC_BIT_ROUTE_LO = 0;
  localparam int ACC_BIT_CMP_IRQ = 7;
  localparam int ACC_BIT_CMP_WAKE = 1;
  localparam logic [1:0] ACC_ROUTE_PIN = 2'h2;

  // ==========================================================================
  // Reset values, wake write mask and full ratio
  localparam logic [3:0] ACC_RATIO_RESET = 4'hF;
  localparam logic [7:0] ACC_CTRL_RESET = 8'hF8;
  localparam logic [7:0] ACC_WAKE_WMASK = 8'h07;
  localparam logic [3:0] ACC_RATIO_FULL = 4'hF;

endpackage

// [hdl/acc_sync.sv]
// Two-stage synchroniser for the comparator result
`timescale 1ns/1ps
module acc_sync (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Data
  input wire logic async_in,
  output logic sync_out
);
  logic meta_reg;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule

// [hdl/acc_top.sv]
// Analog comparator control: registers, reference select, change detect, wake
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
module acc_top (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Analog front end
  input wire logic cmp_raw,
  output logic cmp_enable,
  output logic internal_ref_select_n,
  output logic [3:0] ref_ratio_select,
  // Pins
  output logic cmp_out_pin,
  output logic cmp_out_pin_oe,
  // Shared pin requests from other blocks
  input wire logic conv_ref_req,
  input wire logic conv_ch4_req,
  input wire logic conv_ch3_req,
  output logic [3:0] neg_pin_grant,
  output logic [2:0] pos_pin_grant,
  // Core interface
  input wire logic global_irq_enable_instr,
  input wire logic sleep_mode,
  output logic cmp_irq_req,
  output logic cmp_wakeup
);
  logic [7:0] ctrl_reg;
  logic [7:0] wake_reg;
  logic cmp_irq_flag_reg;
  logic cmp_irq_mask_reg;
  logic cmp_en_reg;
  logic result_sync;
  logic result_prev_reg;
  logic [3:0] neg_grant;
  logic [2:0] pos_grant;

  // ==========================================================================
  // Address decode
  wire page_hi = reg_addr[7];
  wire [7:0] ofs = reg_addr & ~acc_pkg::ACC_PAGE_BIT;
  wire hit_ctrl = (ofs == acc_pkg::ACC_OFS_CMP_CTRL) && !page_hi;
  wire hit_wake = (ofs == acc_pkg::ACC_OFS_WAKE_CTRL) && !page_hi;
  wire hit_stat = (ofs == acc_pkg::ACC_OFS_IRQ_STATUS) && !page_hi;
  wire hit_mask = (ofs == acc_pkg::ACC_OFS_IRQ_MASK) && page_hi;
  wire hit_en = (ofs == 8'h00) && page_hi;

  // ==========================================================================
  // Comparator enable register (only bit 0 used)
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_en_reg <= 1'b0;
    end else if (reg_wr && hit_en) begin
      cmp_en_reg <= reg_wdata[0];
    end
  end

  // ==========================================================================
  // Control and wake registers; result bit is read only
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= acc_pkg::ACC_CTRL_RESET;
      wake_reg <= 8'h00;
      cmp_irq_mask_reg <= 1'b0;
    end else begin
      if (reg_wr && hit_ctrl) begin
        ctrl_reg <= reg_wdata;
      end
      if (reg_wr && hit_wake) begin
        wake_reg <= reg_wdata & acc_pkg::ACC_WAKE_WMASK;
      end
      if (reg_wr && hit_mask) begin
        cmp_irq_mask_reg <= reg_wdata[acc_pkg::ACC_BIT_CMP_IRQ];
      end
    end
  end

  // ==========================================================================
  // Result synchroniser and change detection
  acc_sync acc_sync_i (
    .mclk(mclk),
    .rstn(rstn),
    .async_in(cmp_raw), // R1
    .sync_out(result_sync) // R15
  );

  // Detection runs on mclk in Sleep too, only the enable gates it
  wire cmp_change = cmp_en_reg && (result_sync != result_prev_reg); // R7 R9

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      result_prev_reg <= 1'b0;
    end else begin
      result_prev_reg <= result_sync; // R15
    end
  end

  // ==========================================================================
  // Sticky interrupt flag: set wins over a software clear
  wire flag_clr = reg_wr && hit_stat && !reg_wdata[acc_pkg::ACC_BIT_CMP_IRQ];
  wire flag_next = cmp_change ? 1'b1 : (flag_clr ? 1'b0 : cmp_irq_flag_reg); // R7 R8

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_irq_flag_reg <= 1'b0;
    end else begin
      cmp_irq_flag_reg <= flag_next; // R8
    end
  end

  // ==========================================================================
  // Read data, one cycle after the strobe
  wire [7:0] ctrl_view = {ctrl_reg[7:3], result_prev_reg, ctrl_reg[1:0]}; // R4
  wire [7:0] rd_mux = !reg_rd ? 8'h00 :
                      hit_ctrl ? ctrl_view :
                      hit_wake ? wake_reg :
                      hit_stat ? {cmp_irq_flag_reg, 7'h00} :
                      hit_mask ? {cmp_irq_mask_reg, 7'h00} :
                      hit_en ? {7'h00, cmp_en_reg} : 8'h00;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // ==========================================================================
  // Shared pin priority
  acc_pinmux acc_pinmux_i (
    .neg_conv_ref_req(conv_ref_req),
    .neg_cmp_req(cmp_en_reg),
    .neg_conv_ch_req(conv_ch4_req),
    .pos_cmp_req(cmp_en_reg),
    .pos_conv_ch_req(conv_ch3_req),
    .neg_grant(neg_grant),
    .pos_grant(pos_grant)
  );

  // ==========================================================================
  // Registered outputs
  wire route_pin = ctrl_reg[acc_pkg::ACC_BIT_ROUTE_HI:acc_pkg::ACC_BIT_ROUTE_LO]
                   == acc_pkg::ACC_ROUTE_PIN;
  wire wake_next = sleep_mode && cmp_change && wake_reg[acc_pkg::ACC_BIT_CMP_WAKE];
  wire irq_next = (flag_next && cmp_irq_mask_reg && global_irq_enable_instr)
                  || wake_next;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cmp_enable <= 1'b0;
      internal_ref_select_n <= 1'b1;
      ref_ratio_select <= acc_pkg::ACC_RATIO_RESET;
      cmp_out_pin <= 1'b0;
      cmp_out_pin_oe <= 1'b0;
      neg_pin_grant <= 4'h1;
      pos_pin_grant <= 3'h1;
      cmp_irq_req <= 1'b0;
      cmp_wakeup <= 1'b0;
    end else begin
      cmp_enable <= cmp_en_reg;
      internal_ref_select_n <= ctrl_reg[acc_pkg::ACC_BIT_REF_SEL_N]; // R2
      ref_ratio_select <= ctrl_reg[acc_pkg::ACC_BIT_RATIO_HI:acc_pkg::ACC_BIT_RATIO_LO]; // R3
      cmp_out_pin <= route_pin && result_sync; // R5
      cmp_out_pin_oe <= route_pin; // R5
      neg_pin_grant <= neg_grant;
      pos_pin_grant <= pos_grant;
      cmp_irq_req <= irq_next; // R6 R10
      cmp_wakeup <= wake_next; // R10 R14
    end
  end
endmodule

// [sim/acc_analog.sv]
// Analog model of the two comparator input pins
`timescale 1ns/1ps
module acc_analog (
  // Reference control from the block
  input wire logic internal_ref_select_n,
  input wire logic [3:0] ref_ratio_select,
  // Pin levels in fifteenths of supply
  input wire logic [3:0] pos_lvl,
  input wire logic [3:0] neg_lvl,
  // Comparator output
  output logic cmp_raw
);
  wire logic [3:0] neg_in = internal_ref_select_n ? neg_lvl : ref_ratio_select;
  assign cmp_raw = pos_lvl > neg_in;
endmodule

// [sim/acc_asserts.sv]
// Port assertions for the comparator control block
`timescale 1ns/1ps
module acc_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched ports
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic internal_ref_select_n,
  input wire logic [3:0] ref_ratio_select,
  input wire logic cmp_out_pin_oe,
  input wire logic [3:0] neg_pin_grant,
  input wire logic [2:0] pos_pin_grant,
  input wire logic global_irq_enable_instr,
  input wire logic sleep_mode,
  input wire logic cmp_irq_req,
  input wire logic cmp_wakeup
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic up;
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) up <= 1'b0;
    else up <= 1'b1;
  end
  ref_write_a: assert property (up && $past(reg_wr, 2) && $past(reg_addr, 2) == 8'h09 |->
    {internal_ref_select_n, ref_ratio_select} == $past(reg_wdata[7:3], 2))
    else $error("reference select differs from write");
  route_on_a: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[1:0] == 2'h2 |->
    ##2 cmp_out_pin_oe) else $error("output pin not enabled");
  route_off_a: assert property (reg_wr && reg_addr == 8'h09 && reg_wdata[1:0] != 2'h2 |->
    ##2 !cmp_out_pin_oe) else $error("output pin enabled");
  irq_gate_a: assert property (up && cmp_irq_req && !cmp_wakeup |->
    $past(global_irq_enable_instr)) else $error("request without global enable");
  wake_sleep_a: assert property (up && cmp_wakeup |-> $past(sleep_mode) && cmp_irq_req)
    else $error("wake outside sleep");
  wake_pulse_a: assert property (cmp_wakeup |=> !cmp_wakeup)
    else $error("wake longer than one cycle");
  irq_hold_a: assert property (up && cmp_irq_req && !cmp_wakeup && !reg_wr &&
    !$past(reg_wr) && global_irq_enable_instr |=> cmp_irq_req)
    else $error("request dropped without clear");
  rdata_idle_a: assert property (up && !$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  grant_one_a: assert property ($onehot(neg_pin_grant) && $onehot(pos_pin_grant))
    else $error("pin grant not one-hot");
endmodule
bind acc_top acc_asserts acc_asserts_i (.*);

// [sim/tb_analog_comparator_control.sv]
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module tb_analog_comparator_control;
  logic mclk, rstn, reg_wr, reg_rd, cmp_raw, cmp_enable, internal_ref_select_n, seen;
  logic cmp_out_pin, cmp_out_pin_oe, conv_ref_req, conv_ch4_req, conv_ch3_req;
  logic global_irq_enable_instr, sleep_mode, cmp_irq_req, cmp_wakeup;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [3:0] ref_ratio_select, neg_pin_grant, pos_lvl, neg_lvl;
  logic [2:0] pos_pin_grant;
  int fail_count = 0, checks_done = 0, cyc = 0;
  acc_top acc_top_i (.*);
  acc_analog acc_analog_i (.*);
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp, string what);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
    #1 chk(what, exp, reg_rdata);
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic watch;
    seen = 1'b0;
    repeat (6) @(posedge mclk) #1 seen = seen | cmp_wakeup;
  endtask
  task automatic t_regs;
    rd(8'h09, 8'hF8, "ctrl reset");
    wr(8'h09, 8'h04);
    rd(8'h09, 8'h00, "result read only");
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h00, "unmapped");
    $display("test regs done");
  endtask
  task automatic t_change;
    wr(8'h80, 8'h01);
    wr(8'h8F, 8'h80);
    wr(8'h09, 8'h40);
    global_irq_enable_instr <= 1'b1;
    @(posedge mclk) pos_lvl <= 4'h9;
    wt(4);
    chk("irq on rise", 8'h01, {7'h0, cmp_irq_req});
    chk("enable out", 8'h01, {7'h0, cmp_enable});
    rd(8'h09, 8'h44, "result high");
    wr(8'h0F, 8'h00);
    rd(8'h0F, 8'h00, "flag clear");
    @(posedge mclk) pos_lvl <= 4'h8;
    wt(8);
    rd(8'h0F, 8'h80, "flag on fall");
    @(posedge mclk) global_irq_enable_instr <= 1'b0;
    wt(2);
    chk("irq gated", 8'h00, {7'h0, cmp_irq_req});
    $display("test change done");
  endtask
  task automatic t_route;
    wr(8'h09, 8'h42);
    wt(2);
    chk("pin low", 8'h02, {6'h0, cmp_out_pin_oe, cmp_out_pin});
    @(posedge mclk) pos_lvl <= 4'hF;
    wt(5);
    chk("pin high", 8'h03, {6'h0, cmp_out_pin_oe, cmp_out_pin});
    wr(8'h09, 8'h41);
    wt(2);
    chk("pin off", 8'h00, {7'h0, cmp_out_pin_oe});
    $display("test route done");
  endtask
  task automatic t_sleep;
    wr(8'h0D, 8'h02);
    sleep_mode <= 1'b1;
    @(posedge mclk) pos_lvl <= 4'h0;
    watch();
    chk("wake", 8'h01, {7'h0, seen});
    wr(8'h0D, 8'h00);
    @(posedge mclk) pos_lvl <= 4'hF;
    watch();
    chk("no wake", 8'h00, {7'h0, seen});
    wr(8'h0D, 8'h02);
    wr(8'h80, 8'h00);
    @(posedge mclk) pos_lvl <= 4'h0;
    watch();
    chk("off no wake", 8'h00, {7'h0, seen});
    wr(8'h80, 8'h01);
    sleep_mode <= 1'b0;
    $display("test sleep done");
  endtask
  task automatic t_mux;
    @(posedge mclk) conv_ref_req <= 1'b1;
    wt(2);
    chk("neg ref", 8'h08, {4'h0, neg_pin_grant});
    @(posedge mclk) {conv_ref_req, conv_ch4_req, conv_ch3_req} <= 3'h3;
    wr(8'h09, 8'hC0);
    wt(2);
    chk("cmp pins", 8'h44, {1'b0, pos_pin_grant, neg_pin_grant});
    wr(8'h80, 8'h00);
    wt(2);
    chk("conv pins", 8'h22, {1'b0, pos_pin_grant, neg_pin_grant});
    @(posedge mclk) {conv_ch4_req, conv_ch3_req} <= 2'h0;
    wt(2);
    chk("port pins", 8'h11, {1'b0, pos_pin_grant, neg_pin_grant});
    $display("test mux done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count++;
      conclude();
    end
  end
  initial begin
    {rstn, reg_wr, reg_rd, conv_ref_req, conv_ch4_req, conv_ch3_req} = '0;
    {global_irq_enable_instr, sleep_mode, reg_addr, reg_wdata} = '0;
    {pos_lvl, neg_lvl} = 8'h07;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_change();
    t_route();
    t_sleep();
    t_mux();
    conclude();
  end
endmodule
